// File: verilog/fci_host.sv
`timescale 1ns/1ps
// Purpose: host controller issuing flash command sequences
// Assumes: user holds op stable while o_ready is low after i_start
// Notes:   polls the busy pin, then for program commands bit 7 back to its true value, for completion
module fci_host
  import fci_pkg::*;
#(
  parameter int unsigned PROG_CYC  = CYC_PROG,
  parameter longint      ERASE_CYC = CYC_ERASE,
  parameter int unsigned READY_CYC = CYC_READY,
  parameter int unsigned SPD_CYC   = CYC_SPD
)(
  input  wire logic             i_clk,
  input  wire logic             i_rst_b,
  input  wire logic             i_start,
  input  wire fci_pkg::fci_op_t i_op,
  input  wire logic [21:0]      i_addr,
  input  wire logic [15:0]      i_data,
  input  wire logic             i_hv_reset,
  input  wire logic             i_hidden,
  input  wire logic             i_flash_reset,
  input  wire logic [15:0]      i_dq_in,
  input  wire logic             i_rdy_busy_b,
  output logic                  o_ready,
  output logic                  o_done,
  output logic                  o_error,
  output logic                  o_timeout,
  output logic      [15:0]      o_rdata,
  output logic                  o_fast_mode,
  output logic      [21:0]      o_addr,
  output logic      [15:0]      o_dq_out,
  output logic                  o_dq_oe_b,
  output logic                  o_cs_b,
  output logic                  o_we_b,
  output logic                  o_oe_b,
  output logic                  o_reset_b
);
  // A zero wait count would end every wait before it starts
  if (PROG_CYC < 1 || ERASE_CYC < 1 || READY_CYC < 1 || SPD_CYC < 1) begin
    $error("fci_host: wait counts must be at least one");
  end

  typedef enum {H_IDLE, H_CYC, H_POLL, H_RSTPIN, H_RSTWAIT} fci_hst_t;
  fci_hst_t     st;
  fci_op_t      op;
  logic [2:0]   idx, nlast;
  logic [21:0]  tgt;
  logic [15:0]  wd;
  logic [39:0]  wait_cnt, wait_max;
  logic         rb_s1, rb_s2, rb_s3, rb_busy;
  logic         poll_rd, poll_phase;
  logic [21:0]  next_addr;
  logic [15:0]  next_data;
  logic         next_wr;
  fci_cyc_if    cyc ();

  // ---------------------------------------------------------------
  // Command table
  // ---------------------------------------------------------------
  function automatic logic [2:0] fci_len(input fci_op_t o);
    case (o)
      FCI_OP_RESET1, FCI_OP_PSUSP, FCI_OP_PRESUME, FCI_OP_ESUSP,
      FCI_OP_ERESUME, FCI_OP_QUERY, FCI_OP_READ: fci_len = 3'd1;
      FCI_OP_FAST_PROG, FCI_OP_FAST_EXIT:      fci_len = 3'd2;
      FCI_OP_RESET3, FCI_OP_AUTOSEL, FCI_OP_FAST_SET: fci_len = 3'd3;
      FCI_OP_PROGRAM, FCI_OP_PROTECT:          fci_len = 3'd4;
      default:                                 fci_len = 3'd6;
    endcase
  endfunction

  function automatic logic [21:0] fci_unl(input logic [10:0] a,
                                          input logic [21:0] t);
    fci_unl = {t[21:11], a};
  endfunction

  function automatic logic fci_is_wait(input fci_op_t o);
    fci_is_wait = (o == FCI_OP_PROGRAM) || (o == FCI_OP_FAST_PROG) ||
                  (o == FCI_OP_CHIP_ERASE) || (o == FCI_OP_SECT_ERASE) ||
                  (o == FCI_OP_ESUSP) || (o == FCI_OP_PSUSP);
  endfunction

  // Bank-addressed cycles keep only bits 21..19; unlock cycles keep
  // the bank too, so a hidden-region access lands in bank zero.
  always_comb begin
    next_wr   = 1'b1;
    next_addr = fci_unl(FCI_UNLOCK_A, tgt);
    next_data = FCI_D_AA;
    if (idx == 3'd1 || idx == 3'd4) begin
      next_addr = fci_unl(FCI_UNLOCK_B, tgt);
      next_data = FCI_D_55;
    end
    case (op)
      FCI_OP_RESET1: next_data = FCI_D_RESET;
      FCI_OP_RESET3: if (idx == 3'd2) next_data = FCI_D_RESET;
      FCI_OP_AUTOSEL: if (idx == 3'd2) next_data = FCI_D_AUTOSEL;
      FCI_OP_PROGRAM: begin
        if (idx == 3'd2) next_data = FCI_D_PROG;
        if (idx == 3'd3) begin
          next_addr = tgt;
          next_data = wd;
        end
      end
      FCI_OP_PSUSP, FCI_OP_ESUSP: begin
        next_addr = {tgt[FCI_BANK_HI:FCI_BANK_LO], 19'h0};
        next_data = FCI_D_SUSP;
      end
      FCI_OP_PRESUME, FCI_OP_ERESUME: begin
        next_addr = {tgt[FCI_BANK_HI:FCI_BANK_LO], 19'h0};
        next_data = FCI_D_RESUME;
      end
      FCI_OP_CHIP_ERASE, FCI_OP_SECT_ERASE: begin
        if (idx == 3'd2) next_data = FCI_D_ERASE;
        if (idx == 3'd5) begin
          if (op == FCI_OP_SECT_ERASE) begin
            next_addr = {tgt[21:FCI_SECT_LO], 12'h000};
            next_data = FCI_D_SECTOR;
          end else begin
            next_data = FCI_D_CHIP;
          end
        end
      end
      FCI_OP_FAST_SET: if (idx == 3'd2) next_data = FCI_D_FAST;
      FCI_OP_FAST_PROG: begin
        next_addr = (idx == 3'd0) ? 22'h0 : tgt;
        next_data = (idx == 3'd0) ? FCI_D_PROG : wd;
      end
      FCI_OP_FAST_EXIT: begin
        next_addr = {tgt[FCI_BANK_HI:FCI_BANK_LO], 19'h0};
        next_data = (idx == 3'd0) ? FCI_D_AUTOSEL : FCI_D_RESET;
      end
      FCI_OP_PROTECT: begin
        // Group address on top, fixed pattern on A6,A3..A0
        next_addr = {tgt[21:FCI_SECT_LO], 5'h00, FCI_PROT_LOW};
        next_data = (idx == 3'd2) ? FCI_D_PROT3 : FCI_D_PROT1;
        if (idx == 3'd0) next_addr = 22'h0;
        if (idx == 3'd3) next_wr = 1'b0;      // verify read
      end
      FCI_OP_QUERY: begin
        next_addr = {tgt[FCI_BANK_HI:FCI_BANK_LO], 8'h00, FCI_QUERY_A};
        next_data = FCI_D_QUERY;
      end
      FCI_OP_READ: begin
        next_addr = tgt;
        next_wr   = 1'b0;
      end
      default: next_data = FCI_D_RESET;
    endcase
    if (poll_rd) begin
      next_addr = tgt;
      next_wr   = 1'b0;
    end
  end

  assign cyc.addr  = next_addr;
  assign cyc.wdata = next_data;
  assign cyc.wr    = next_wr;

  // ---------------------------------------------------------------
  // Busy pin sampling
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    rb_s1 <= i_rdy_busy_b;
    rb_s2 <= rb_s1;
    rb_s3 <= rb_s2;
    if (rb_s2 == rb_s3) rb_busy <= !rb_s3;
  end

  // ---------------------------------------------------------------
  // Sequencer
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      st <= H_IDLE; op <= FCI_OP_READ; idx <= 3'd0; nlast <= 3'd0;
      tgt <= '0; wd <= 16'h0000; wait_cnt <= '0; wait_max <= '0;
      poll_rd <= 1'b0; poll_phase <= 1'b0; cyc.req <= 1'b0;
      o_ready <= 1'b0; o_done <= 1'b0; o_error <= 1'b0;
      o_timeout <= 1'b0; o_rdata <= 16'h0000; o_fast_mode <= 1'b0;
      o_reset_b <= 1'b1;
    end else begin
      o_done  <= 1'b0;
      o_error <= 1'b0;
      case (st)
        H_IDLE: begin
          o_ready <= 1'b1;
          if (i_flash_reset) begin
            o_ready  <= 1'b0;
            o_reset_b <= 1'b0;
            wait_cnt <= '0;
            st       <= H_RSTPIN;
          end else if (i_start) begin
            o_ready <= 1'b0;
            // Refuse commands outside their mode
            if ((i_op == FCI_OP_FAST_PROG || i_op == FCI_OP_FAST_EXIT)
                && !o_fast_mode ||
                i_op == FCI_OP_PROTECT && !i_hv_reset ||
                i_hidden && i_addr > FCI_HIDDEN_TOP) begin
              o_error <= 1'b1;
              st      <= H_IDLE;
            end else begin
              op  <= i_op;  tgt <= i_addr;  wd <= i_data;
              idx <= 3'd0;  nlast <= fci_len(i_op) - 3'd1;
              cyc.req <= 1'b1;
              st  <= H_CYC;
            end
          end
        end
        H_CYC: begin
          if (cyc.ack) begin
            if (!cyc.wr) o_rdata <= cyc.rdata;
            if (idx == nlast) begin
              cyc.req <= 1'b0;
              if (op == FCI_OP_FAST_SET) o_fast_mode <= 1'b1;
              if (op == FCI_OP_FAST_EXIT) o_fast_mode <= 1'b0;
              if (fci_is_wait(op)) begin
                wait_cnt <= '0;
                wait_max <= (op == FCI_OP_CHIP_ERASE ||
                             op == FCI_OP_SECT_ERASE) ? 40'(ERASE_CYC) :
                            (op == FCI_OP_ESUSP || op == FCI_OP_PSUSP) ?
                            40'(SPD_CYC) : 40'(PROG_CYC);
                poll_phase <= 1'b0;
                st <= H_POLL;
              end else begin
                o_done <= 1'b1;
                st     <= H_IDLE;
              end
            end else begin
              idx <= idx + 3'd1;
              cyc.req <= 1'b0;
              st <= H_CYC;
            end
          end else begin
            cyc.req <= 1'b1;
          end
        end
        H_POLL: begin
          // Wait out the busy delay before trusting the busy pin
          wait_cnt <= wait_cnt + 40'd1;
          if (wait_cnt >= wait_max) begin
            // Drop a pending poll so the next command is not overridden
            o_timeout <= 1'b1;
            o_error   <= 1'b1;
            poll_rd   <= 1'b0;
            cyc.req   <= 1'b0;
            st        <= H_IDLE;
          end else if (wait_cnt > 40'(CYC_BUSY + 3) && !rb_busy) begin
            if (op == FCI_OP_PROGRAM || op == FCI_OP_FAST_PROG) begin
              // Confirm with a read: bit 7 true again
              if (!poll_phase) begin
                poll_phase <= 1'b1;
                poll_rd <= 1'b1;
                cyc.req <= 1'b1;
              end else if (cyc.ack) begin
                poll_rd <= 1'b0;
                cyc.req <= 1'b0;
                o_rdata <= cyc.rdata;
                poll_phase <= 1'b0;
                if (cyc.rdata[7] == wd[7]) begin
                  o_done <= 1'b1;
                  st <= H_IDLE;
                end
              end
            end else begin
              o_done <= 1'b1;
              st     <= H_IDLE;
            end
          end
        end
        H_RSTPIN: begin
          wait_cnt <= wait_cnt + 40'd1;
          if (wait_cnt >= 40'(CYC_RP)) begin
            o_reset_b <= 1'b1;
            o_fast_mode <= 1'b0;
            wait_cnt <= '0;
            st <= H_RSTWAIT;
          end
        end
        H_RSTWAIT: begin
          wait_cnt <= wait_cnt + 40'd1;
          if (wait_cnt >= 40'(READY_CYC)) begin
            o_done <= 1'b1;
            st <= H_IDLE;
          end
        end
        default: st <= H_IDLE;
      endcase
    end
  end

  fci_bus_engine u_eng (
    .i_clk     (i_clk),
    .i_rst_b   (i_rst_b),
    .cyc       (cyc),
    .i_dq_in   (i_dq_in),
    .o_addr    (o_addr),
    .o_dq_out  (o_dq_out),
    .o_dq_oe_b (o_dq_oe_b),
    .o_cs_b    (o_cs_b),
    .o_we_b    (o_we_b),
    .o_oe_b    (o_oe_b)
  );

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  a_fast_guard: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    st == H_IDLE && i_start && !i_flash_reset &&
    i_op == FCI_OP_FAST_PROG && !o_fast_mode |=> o_error)
    else $error("fast program accepted outside fast mode");
  a_prot_hv: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    st == H_IDLE && i_start && !i_flash_reset &&
    i_op == FCI_OP_PROTECT && !i_hv_reset |=> st == H_IDLE)
    else $error("protect issued without high voltage");
  a_unlock_addr: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    st == H_CYC && cyc.req && next_data == FCI_D_55 && op != FCI_OP_PROGRAM
    && op != FCI_OP_FAST_PROG |-> next_addr[10:0] == FCI_UNLOCK_B)
    else $error("second unlock cycle not at 2aah");
  a_sector_sel: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    st == H_CYC && op == FCI_OP_SECT_ERASE && idx == 3'd5 |->
    next_addr[21:12] == tgt[21:12] && next_addr[11:0] == 12'h000)
    else $error("sector address not on bits 21..12");
  a_bank_bits: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    st == H_CYC && (op == FCI_OP_ESUSP || op == FCI_OP_ERESUME) |->
    next_addr[21:19] == tgt[21:19] && next_data[7:4] != 4'h0)
    else $error("bank address wrong");
  a_prot_pattern: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    st == H_CYC && op == FCI_OP_PROTECT && idx != 3'd0 |->
    (next_addr[6:0] & FCI_PROT_MASK) == FCI_PROT_LOW)
    else $error("protect pattern wrong");
  a_reset_width: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    $fell(o_reset_b) |-> !o_reset_b [*8])
    else $error("reset pulse too short");
  a_hidden_rng: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    st == H_IDLE && i_start && !i_flash_reset && i_hidden &&
    i_addr > FCI_HIDDEN_TOP |=> o_error)
    else $error("hidden access outside region accepted");
  a_prog_data: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    st == H_CYC && op == FCI_OP_PROGRAM && idx == 3'd3 && !poll_rd |->
    next_addr == tgt && next_data == wd)
    else $error("program cycle carries wrong word");
  c_program: cover property (@(posedge i_clk)
    st == H_POLL && op == FCI_OP_PROGRAM ##[1:1000] o_done);
  c_erase: cover property (@(posedge i_clk)
    st == H_POLL && op == FCI_OP_SECT_ERASE);
  c_refused: cover property (@(posedge i_clk) o_error && !o_timeout);
  c_pinreset: cover property (@(posedge i_clk) st == H_RSTWAIT);
endmodule

// File: verilog/fci_pkg.sv
// Purpose: constants shared by the flash command host and its bus engine
// Assumes: 25 MHz system clock, word-mode (x16) parallel flash bus
// Notes:   the host drives command cycles; the flash decodes them
// ---------------------------------------------------------------
// ---------------------------------------------------------------
package fci_pkg;

  localparam int FCI_AW = 22;
  localparam int FCI_DW = 16;

  localparam logic [10:0] FCI_UNLOCK_A = 11'h555;
  localparam logic [10:0] FCI_UNLOCK_B = 11'h2aa;
  localparam logic [15:0] FCI_D_AA     = 16'h00aa;
  localparam logic [15:0] FCI_D_55     = 16'h0055;
  localparam logic [15:0] FCI_D_RESET  = 16'h00f0;
  localparam logic [15:0] FCI_D_AUTOSEL = 16'h0090;
  localparam logic [15:0] FCI_D_PROG   = 16'h00a0;
  localparam logic [15:0] FCI_D_ERASE  = 16'h0080;
  localparam logic [15:0] FCI_D_CHIP   = 16'h0010;
  localparam logic [15:0] FCI_D_SECTOR = 16'h0030;
  localparam logic [15:0] FCI_D_SUSP   = 16'h00b0;
  localparam logic [15:0] FCI_D_RESUME = 16'h0030;
  localparam logic [15:0] FCI_D_FAST   = 16'h0020;
  localparam logic [15:0] FCI_D_PROT1  = 16'h0060;
  localparam logic [15:0] FCI_D_PROT3  = 16'h0040;
  localparam logic [15:0] FCI_D_QUERY  = 16'h0098;
  localparam logic [15:0] FCI_D_HIDDEN = 16'h0088;
  localparam logic [10:0] FCI_QUERY_A  = 11'h055;
  localparam logic [6:0]  FCI_PROT_LOW = 7'h02;
  localparam logic [6:0]  FCI_PROT_MASK = 7'h4f;
  localparam logic [21:0] FCI_HIDDEN_TOP = 22'h00007f;
  localparam logic [7:0]  FCI_PROT_YES = 8'h01;
  localparam logic [7:0]  FCI_PROT_NO  = 8'h00;
  localparam int FCI_BANK_HI = 21;
  localparam int FCI_BANK_LO = 19;
  localparam int FCI_SECT_LO = 12;

  localparam int CLK_NS        = 40;
  localparam int T_WP_NS       = 35;
  localparam int T_WPH_NS      = 25;
  localparam int T_ACC_NS      = 70;
  localparam int T_BUSY_NS     = 90;
  localparam int T_SPD_US      = 20;
  localparam int T_READY_US    = 20;
  localparam int T_RP_NS       = 500;
  localparam int T_PROG_US     = 100;
  localparam int T_ERASE_S     = 2;
  localparam int CYC_WP   = (T_WP_NS + CLK_NS - 1) / CLK_NS;
  localparam int CYC_WPH  = (T_WPH_NS + CLK_NS - 1) / CLK_NS;
  localparam int CYC_ACC  = (T_ACC_NS + CLK_NS - 1) / CLK_NS;
  localparam int CYC_BUSY = (T_BUSY_NS / CLK_NS) + 1;
  localparam int CYC_RP   = (T_RP_NS + CLK_NS - 1) / CLK_NS;
  localparam int CYC_SPD  = T_SPD_US * 1000 / CLK_NS;
  localparam int CYC_READY = T_READY_US * 1000 / CLK_NS;
  localparam int CYC_PROG = T_PROG_US * 1000 / CLK_NS;
  localparam longint CYC_ERASE = longint'(T_ERASE_S) * 64'd1000000000 / CLK_NS;

  typedef enum logic [3:0] {
    FCI_OP_RESET1, FCI_OP_RESET3, FCI_OP_AUTOSEL, FCI_OP_PROGRAM,
    FCI_OP_PSUSP, FCI_OP_PRESUME, FCI_OP_CHIP_ERASE, FCI_OP_SECT_ERASE,
    FCI_OP_ESUSP, FCI_OP_ERESUME, FCI_OP_FAST_SET, FCI_OP_FAST_PROG,
    FCI_OP_FAST_EXIT, FCI_OP_PROTECT, FCI_OP_QUERY, FCI_OP_READ
  } fci_op_t;

endpackage

// File: verilog/fci_cyc_if.sv
`timescale 1ns/1ps
// Purpose: one bus-cycle request between sequencer and pin engine
// Assumes: single clock, same domain on both sides
// Notes:   req held until ack pulses
interface fci_cyc_if;
  logic        req;
  logic        wr;
  logic [21:0] addr;
  logic [15:0] wdata;
  logic        ack;
  logic [15:0] rdata;
  modport seq (output req, output wr, output addr, output wdata,
               input ack, input rdata);
  modport eng (input req, input wr, input addr, input wdata,
               output ack, output rdata);
endinterface

// File: verilog/fci_bus_engine.sv
`timescale 1ns/1ps
// Purpose: drives one asynchronous write or read cycle on the flash pins
// Assumes: flash data pins are sampled through a three-flop stage
// Notes:   address and data stay stable across the whole write pulse
module fci_bus_engine
  import fci_pkg::*;
(
  input  wire logic             i_clk,
  input  wire logic             i_rst_b,
  fci_cyc_if.eng                cyc,
  input  wire logic [15:0]      i_dq_in,
  output logic      [21:0]      o_addr,
  output logic      [15:0]      o_dq_out,
  output logic                  o_dq_oe_b,
  output logic                  o_cs_b,
  output logic                  o_we_b,
  output logic                  o_oe_b
);
  typedef enum {E_IDLE, E_SETUP, E_PULSE, E_HIGH, E_RWAIT} fci_eng_t;
  fci_eng_t   st;
  logic [7:0] cnt;
  logic [15:0] dq_s1, dq_s2, dq_s3;

  // Data pins come from outside the clock domain
  always_ff @(posedge i_clk) begin
    dq_s1 <= i_dq_in;
    dq_s2 <= dq_s1;
    dq_s3 <= dq_s2;
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      st        <= E_IDLE;
      cnt       <= 8'h00;
      o_addr    <= '0;
      o_dq_out  <= 16'h0000;
      o_dq_oe_b <= 1'b1;
      o_cs_b    <= 1'b1;
      o_we_b    <= 1'b1;
      o_oe_b    <= 1'b1;
      cyc.ack   <= 1'b0;
      cyc.rdata <= 16'h0000;
    end else begin
      cyc.ack <= 1'b0;
      case (st)
        E_IDLE: begin
          if (cyc.req && !cyc.ack) begin
            // Address and data latched by the flash at the write edge
            o_addr    <= cyc.addr;
            o_dq_out  <= cyc.wdata;
            o_dq_oe_b <= !cyc.wr;
            o_cs_b    <= 1'b0;
            st        <= E_SETUP;
          end
        end
        E_SETUP: begin
          cnt <= 8'h00;
          if (cyc.wr) begin
            o_we_b <= 1'b0;
            st     <= E_PULSE;
          end else begin
            o_oe_b <= 1'b0;
            st     <= E_RWAIT;
          end
        end
        E_PULSE: begin
          // One cycle beyond the minimum width, as margin on slow edges
          cnt <= cnt + 8'h01;
          if (cnt >= 8'(CYC_WP)) begin
            o_we_b <= 1'b1;
            cnt    <= 8'h00;
            st     <= E_HIGH;
          end
        end
        E_HIGH: begin
          cnt <= cnt + 8'h01;
          if (cnt >= 8'(CYC_WPH)) begin
            o_cs_b    <= 1'b1;
            o_dq_oe_b <= 1'b1;
            cyc.ack   <= 1'b1;
            st        <= E_IDLE;
          end
        end
        E_RWAIT: begin
          // Covers access time plus the three-flop input delay
          cnt <= cnt + 8'h01;
          if (cnt >= 8'(CYC_ACC + 3)) begin
            cyc.rdata <= dq_s3;
            o_oe_b    <= 1'b1;
            o_cs_b    <= 1'b1;
            cyc.ack   <= 1'b1;
            st        <= E_IDLE;
          end
        end
        default: st <= E_IDLE;
      endcase
    end
  end

  a_wp_width: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    $fell(o_we_b) |-> !o_we_b [*2])
    else $error("write pulse too short");
  a_data_stable: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    !o_we_b |-> $stable(o_dq_out) && $stable(o_addr))
    else $error("address or data moved during write pulse");
  c_write: cover property (@(posedge i_clk) $rose(o_we_b));
endmodule

// File: verification/fci_flash_model.sv
`timescale 1ns/1ps
// Purpose: behavioural flash device seen from the host pins
// Assumes: word mode; program, reset and 60h/40h protect sequences decoded
// Notes:   other sequences are dropped, so the array stays unchanged
module fci_flash_model (
  input  wire logic        i_clk,
  input  wire logic [21:0] i_addr,
  input  wire logic [15:0] i_dq,
  input  wire logic        i_cs_b,
  input  wire logic        i_we_b,
  input  wire logic        i_oe_b,
  input  wire logic        i_reset_b,
  output logic      [15:0] o_dq,
  output logic             o_rdy_busy_b
);
  logic [15:0] mem [int];
  logic [21:0] tgt;
  logic [15:0] wd;
  logic [15:0] last = 16'h0000;
  bit          vfy = 0;
  int          step = 0;
  int          busy = 0;
  initial o_dq = 16'h0000;
  assign o_rdy_busy_b = (busy == 0);
  always @(negedge i_we_b) if (!i_cs_b) begin
    // 60h then 40h protects the group; its verify read then gives 01h
    vfy = (i_dq == 16'h0040 && last == 16'h0060);
    last = i_dq;
    if (i_dq == 16'h00f0 && step != 3) step = 0;
    else if (step == 0) step = (i_addr[10:0] == 11'h555 && i_dq == 16'h00aa);
    else if (step == 1) step = (i_addr[10:0] == 11'h2aa) ? 2 : 0;
    else if (step == 2) step = (i_dq == 16'h00a0) ? 3 : 0;
    else begin
      tgt = i_addr;
      wd = i_dq;
      busy = 20;
      step = 0;
    end
  end
  always @(posedge i_clk) begin
    if (!i_reset_b) begin
      busy = 0;
      step = 0;
    end else if (busy > 0) begin
      busy = busy - 1;
      if (busy == 0) mem[tgt] = wd;
    end
    if (!i_cs_b && !i_oe_b && vfy) o_dq <= 16'h0001;
    else if (!i_cs_b && !i_oe_b)
      o_dq <= (busy > 0 && i_addr == tgt) ? {wd[15:8], ~wd[7], wd[6:0]}
            : mem.exists(i_addr) ? mem[i_addr] : 16'hffff;
    else o_dq <= ~o_dq;
  end
endmodule

// File: verification/flash_command_interface_tb.sv
`timescale 1ns/1ps
// Purpose: self-checking bench of the flash command host
// Assumes: long waits shortened to 50 cycles
// Notes:   a word map in the bench predicts every read except the protect verify
module flash_command_interface_tb;
  import fci_pkg::*;
  logic i_clk = 0, i_rst_b = 0, i_start = 0, i_hv_reset = 0;
  logic i_hidden = 0, i_flash_reset = 0, i_rdy_busy_b;
  logic o_ready, o_done, o_error, o_timeout, o_fast_mode;
  logic o_dq_oe_b, o_cs_b, o_we_b, o_oe_b, o_reset_b;
  logic [15:0] i_data = '0, i_dq_in, o_rdata, o_dq_out;
  logic [21:0] i_addr = '0, o_addr, a;
  fci_op_t     i_op = FCI_OP_READ;
  int          err_count = 0, n_tests = 0, n;
  logic [15:0] ref_mem [int];
  logic [31:0] seed = 32'he4fec041;
  fci_host #(.PROG_CYC(50), .ERASE_CYC(50), .READY_CYC(50), .SPD_CYC(50))
    fci_host_i (.*);
  fci_flash_model fci_flash_model_i (.i_clk(i_clk), .i_addr(o_addr),
    .i_dq(o_dq_out), .i_cs_b(o_cs_b), .i_we_b(o_we_b), .i_oe_b(o_oe_b),
    .i_reset_b(o_reset_b), .o_dq(i_dq_in), .o_rdy_busy_b(i_rdy_busy_b));
  initial forever #20 i_clk = ~i_clk;
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic chk(string nm, logic [15:0] x, logic [15:0] s);
    n_tests++;
    if (s !== x) begin
      err_count++;
      $display("BAD %s exp %h got %h", nm, x, s);
    end
  endtask
  task automatic run(fci_op_t op, logic [21:0] ad, logic [15:0] d, bit e);
    n = 0;
    do begin @(posedge i_clk); #1; end while (o_ready !== 1'b1);
    @(posedge i_clk);
    i_op <= op; i_addr <= ad; i_data <= d; i_start <= 1'b1;
    @(posedge i_clk);
    i_start <= 1'b0;
    // A refusal pulses o_error right after the take edge
    #1;
    while (o_done !== 1'b1 && o_error !== 1'b1 && n < 5000) begin
      @(posedge i_clk);
      #1;
      n++;
    end
    chk("error", {15'h0, e}, {15'h0, o_error});
    chk("done", {15'h0, !e}, {15'h0, o_done});
  endtask
  task automatic rd(logic [21:0] ad);
    run(FCI_OP_READ, ad, 16'h0, 0);
    chk("rdata", ref_mem.exists(ad) ? ref_mem[ad] : 16'hffff, o_rdata);
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    #(20000 * CLK_NS);
    err_count++;
    test_done;
  end
  initial begin
    repeat (4) @(posedge i_clk);
    i_rst_b <= 1'b1;
    for (int k = 0; k < 4; k++) begin
      a = 22'(xs());
      ref_mem[a] = 16'(xs());
      run(FCI_OP_PROGRAM, a, ref_mem[a], 0);
      rd(a);
    end
    $display("program test ended");
    run(FCI_OP_FAST_PROG, a, 16'h0, 1);
    run(FCI_OP_FAST_EXIT, a, 16'h0, 1);
    run(FCI_OP_PROTECT, a, 16'h0, 1);
    rd(a);
    i_hidden <= 1'b1;
    run(FCI_OP_READ, 22'h000080, 16'h0, 1);
    rd(22'h00007f);
    i_hidden <= 1'b0;
    run(FCI_OP_FAST_SET, a, 16'h0, 0);
    chk("fast on", 16'h0001, {15'h0, o_fast_mode});
    run(FCI_OP_FAST_EXIT, a, 16'h0, 0);
    chk("fast off", 16'h0000, {15'h0, o_fast_mode});
    $display("refusal test ended");
    run(FCI_OP_RESET1, 22'h0, 16'h0, 0);
    run(FCI_OP_RESET3, 22'h0, 16'h0, 0);
    rd(a);
    @(posedge i_clk);
    i_flash_reset <= 1'b1;
    @(posedge i_clk);
    i_flash_reset <= 1'b0;
    n = 0;
    while (o_reset_b !== 1'b0 && n < 20) begin @(posedge i_clk); #1; n++; end
    chk("pin reset", 16'h0, {15'h0, o_reset_b});
    rd(a);
    $display("reset test ended");
    i_hv_reset <= 1'b1;
    run(FCI_OP_PROTECT, a, 16'h0, 0);
    chk("verify", {8'h00, FCI_PROT_YES}, o_rdata);
    i_hv_reset <= 1'b0;
    run(FCI_OP_SECT_ERASE, a, 16'h0, 0);
    run(FCI_OP_ESUSP, a, 16'h0, 0);
    run(FCI_OP_ERESUME, a, 16'h0, 0);
    chk("timeout", 16'h0000, {15'h0, o_timeout});
    $display("erase test ended");
    test_done;
  end
endmodule
